// ==== logic/ppo_pkg.sv ====
package ppo_pkg;
    typedef logic [7:0] ppo_byte_t;
    typedef logic [1:0] ppo_sel_t;
endpackage : ppo_pkg

// ==== logic/ppo_regs.svh ====
`ifndef PPO_REGS_SVH
`define PPO_REGS_SVH
`define PPO_ADDR_W          4
`define PPO_ENA_HI          4'h0
`define PPO_ENA_LO          4'h1
`define PPO_OUT_HI          4'h2
`define PPO_OUT_LO          4'h3
`define PPO_STG_HI          4'h4
`define PPO_STG_LO          4'h5
`define PPO_STG_HI_ALT      4'h6
`define PPO_STG_LO_ALT      4'h7
`define PPO_TRIG_SEL        4'h8
`define PPO_ENA_RST         8'h00
`define PPO_OUT_RST         8'h00
`define PPO_STG_RST         8'h00
`define PPO_TRIG_SEL_RST    8'hff
`endif

// ==== logic/ppo_top.sv ====
`include "ppo_regs.svh"
module ppo_top
    import ppo_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    // Register port
    input  wire logic [`PPO_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // Timer compare-match events, channels 3..0
    input  wire logic [3:0]             timer_match,
    // Pulse output pins
    output logic      [15:0]            pulse_out
);

////////////////////////////////////////////////////////////////////////////////
    ppo_byte_t   ena_hi_ff, ena_lo_ff, out_hi_ff, out_lo_ff;
    ppo_byte_t   stg_hi_ff, stg_lo_ff, sel_ff;
    logic [7:0]  rdata_ff;
    logic [3:0]  grp_trig;
    logic [15:0] ena_all, stg_all, nxt_out;
    logic        hi_same, lo_same;

    // Write with nibble split per trigger sharing
    function automatic ppo_byte_t stg_wr(input ppo_byte_t old, input ppo_byte_t wd,
                                         input logic same, input logic alt,
                                         input logic [3:0] a);
        ppo_byte_t r;
        r = old;
        if (same) begin
            if (a == `PPO_STG_HI || a == `PPO_STG_LO)
                r = wd;
        end else if (alt) begin
            r[3:0] = wd[3:0];
        end else begin
            r[7:4] = wd[7:4];
        end
        return r;
    endfunction : stg_wr

    function automatic ppo_byte_t stg_rd(input ppo_byte_t v, input logic same,
                                         input logic alt);
        ppo_byte_t r;
        r = v;
        if (!same)
            r = alt ? {4'hf, v[3:0]} : {v[7:4], 4'hf};
        return r;
    endfunction : stg_rd

////////////////////////////////////////////////////////////////////////////////
    // trigger channel select
    always_comb begin
        for (int g = 0; g < 4; g++)
            grp_trig[g] = timer_match[sel_ff[2*g +: 2]];
    end

    assign hi_same = (sel_ff[7:6] == sel_ff[5:4]);
    assign lo_same = (sel_ff[3:2] == sel_ff[1:0]);
    assign ena_all = {ena_hi_ff, ena_lo_ff};
    assign stg_all = {stg_hi_ff, stg_lo_ff};

////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ena_hi_ff <= `PPO_ENA_RST;
            ena_lo_ff <= `PPO_ENA_RST;
        end else if (reg_wr && reg_addr == `PPO_ENA_HI) begin
            ena_hi_ff <= reg_wdata;
        end else if (reg_wr && reg_addr == `PPO_ENA_LO) begin
            ena_lo_ff <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            sel_ff <= `PPO_TRIG_SEL_RST;
        else if (reg_wr && reg_addr == `PPO_TRIG_SEL)
            sel_ff <= reg_wdata;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stg_hi_ff <= `PPO_STG_RST;
            stg_lo_ff <= `PPO_STG_RST;
        end else if (reg_wr) begin
            if (reg_addr == `PPO_STG_HI || reg_addr == `PPO_STG_HI_ALT)
                stg_hi_ff <= stg_wr(stg_hi_ff, reg_wdata, hi_same,
                                    reg_addr == `PPO_STG_HI_ALT, reg_addr);
            if (reg_addr == `PPO_STG_LO || reg_addr == `PPO_STG_LO_ALT)
                stg_lo_ff <= stg_wr(stg_lo_ff, reg_wdata, lo_same,
                                    reg_addr == `PPO_STG_LO_ALT, reg_addr);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // four independent groups
    always_comb begin
        nxt_out = {out_hi_ff, out_lo_ff};
        if (reg_wr && reg_addr == `PPO_OUT_HI)
            nxt_out[15:8] = (out_hi_ff & ena_hi_ff) | (reg_wdata & ~ena_hi_ff);
        if (reg_wr && reg_addr == `PPO_OUT_LO)
            nxt_out[7:0] = (out_lo_ff & ena_lo_ff) | (reg_wdata & ~ena_lo_ff);
        for (int b = 0; b < 16; b++)
            if (grp_trig[b/4] && ena_all[b])
                nxt_out[b] = stg_all[b];
    end

    // Output data register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_hi_ff <= `PPO_OUT_RST;
            out_lo_ff <= `PPO_OUT_RST;
        end else begin
            out_hi_ff <= nxt_out[15:8];
            out_lo_ff <= nxt_out[7:0];
        end
    end

    assign pulse_out = {out_hi_ff, out_lo_ff};

////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PPO_ENA_HI:     rdata_ff <= ena_hi_ff;
                `PPO_ENA_LO:     rdata_ff <= ena_lo_ff;
                `PPO_OUT_HI:     rdata_ff <= out_hi_ff;
                `PPO_OUT_LO:     rdata_ff <= out_lo_ff;
                `PPO_STG_HI:     rdata_ff <= stg_rd(stg_hi_ff, hi_same, 1'b0);
                `PPO_STG_LO:     rdata_ff <= stg_rd(stg_lo_ff, lo_same, 1'b0);
                `PPO_STG_HI_ALT: rdata_ff <= hi_same ? 8'h00 : {4'hf, stg_hi_ff[3:0]};
                `PPO_STG_LO_ALT: rdata_ff <= lo_same ? 8'h00 : {4'hf, stg_lo_ff[3:0]};
                `PPO_TRIG_SEL:   rdata_ff <= sel_ff;
                default:         rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = rdata_ff;

////////////////////////////////////////////////////////////////////////////////
    // enabled transfer
    a_xfer_enabled: assert property (@(posedge mclk) disable iff (!arst_n)
        (grp_trig[0] && ena_lo_ff[0]) |=> pulse_out[0] == $past(stg_lo_ff[0]))
        else $error("enabled bit 0 missed transfer");
    a_xfer_blocked: assert property (@(posedge mclk) disable iff (!arst_n)
        (grp_trig[3] && !ena_hi_ff[7] && !(reg_wr && reg_addr == `PPO_OUT_HI))
        |=> $stable(pulse_out[15]))
        else $error("disabled bit 15 changed");
    a_write_locked: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_wr && reg_addr == `PPO_OUT_LO && ena_lo_ff == 8'hff && !(|grp_trig[1:0]))
        |=> $stable(pulse_out[7:0]))
        else $error("locked output data was written");
    a_write_open: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_wr && reg_addr == `PPO_OUT_HI && ena_hi_ff == 8'h00)
        |=> pulse_out[15:8] == $past(reg_wdata))
        else $error("open output data not written");
    a_sel_reset: assert property (@(posedge mclk)
        $rose(arst_n) |-> sel_ff == 8'hff)
        else $error("trigger select not at reset value");
    a_nibble_ones: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_rd && reg_addr == `PPO_STG_HI && !hi_same) |=> reg_rdata[3:0] == 4'hf)
        else $error("reserved nibble not read as ones");
    a_trig_route: assert property (@(posedge mclk) disable iff (!arst_n)
        (sel_ff[5:4] == 2'h2 && timer_match[2] && ena_hi_ff[0])
        |=> pulse_out[8] == $past(stg_hi_ff[0]))
        else $error("group 2 ignored channel 2");
    a_byte_shared: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_wr && reg_addr == `PPO_STG_LO && lo_same) |=> stg_lo_ff == $past(reg_wdata))
        else $error("shared staged byte not written");
    a_lo_nibble_ones: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_rd && reg_addr == `PPO_STG_LO_ALT && !lo_same) |=> reg_rdata[7:4] == 4'hf)
        else $error("reserved upper nibble not read as ones");
    a_alt_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_wr && reg_addr == `PPO_STG_HI_ALT && hi_same) |=> $stable(stg_hi_ff))
        else $error("unused staged address was written");
    a_sel_group3: assert property (@(posedge mclk) disable iff (!arst_n)
        (sel_ff[7:6] == 2'h0 && timer_match[0] && ena_hi_ff[7])
        |=> pulse_out[15] == $past(stg_hi_ff[7]))
        else $error("group 3 ignored channel 0");
    a_xfer_group1: assert property (@(posedge mclk) disable iff (!arst_n)
        (grp_trig[1] && ena_lo_ff[4]) |=> pulse_out[4] == $past(stg_lo_ff[4]))
        else $error("enabled bit 4 missed transfer");
    a_group_indep: assert property (@(posedge mclk) disable iff (!arst_n)
        (grp_trig[2] && !grp_trig[3] && !(reg_wr && reg_addr == `PPO_OUT_HI))
        |=> $stable(pulse_out[15:12]))
        else $error("group 3 moved on group 2 trigger");
    a_unmapped_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (reg_rd && reg_addr > `PPO_TRIG_SEL) |=> reg_rdata == 8'h00)
        else $error("unmapped index read not zero");

    // Write then read of the trigger select, one idle cycle between
    sequence s_sel_write;
        reg_wr && reg_addr == `PPO_TRIG_SEL;
    endsequence : s_sel_write
    sequence s_sel_read;
        reg_rd && reg_addr == `PPO_TRIG_SEL;
    endsequence : s_sel_read

    a_sel_readback: assert property (@(posedge mclk) disable iff (!arst_n)
        s_sel_write ##1 !reg_wr ##1 s_sel_read |=> reg_rdata == $past(reg_wdata, 3))
        else $error("trigger select readback wrong");

endmodule : ppo_top

// ==== testbench/ppo_timer_model.sv ====
module ppo_timer_model (
    // Clock
    input  wire logic        mclk,
    // Compare-match pulses, channels 3..0
    output logic      [3:0]  timer_match,
    // Port direction bits of the sixteen pins
    output logic      [15:0] pin_dir
);
    timeunit 1ns;
    timeprecision 1ps;

    initial timer_match = 4'h0;

    initial pin_dir = 16'hffff;

    task automatic fire(input int ch);
        timer_match <= 4'h1 << ch;
        @(posedge mclk);
        timer_match <= 4'h0;
    endtask : fire
endmodule : ppo_timer_model

// ==== testbench/ppo_top_tb.sv ====
`include "ppo_regs.svh"
module ppo_top_tb
    import ppo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   mclk      = 1'b0;
    logic                   arst_n    = 1'b0;
    logic [`PPO_ADDR_W-1:0] reg_addr  = '0;
    ppo_byte_t              reg_wdata = 8'h00;
    logic                   reg_wr    = 1'b0;
    logic                   reg_rd    = 1'b0;
    ppo_byte_t              reg_rdata;
    logic [3:0]             timer_match;
    logic [15:0]            pulse_out;
    logic [15:0]            pin_dir;
    int                     bad_count  = 0;
    int                     num_checks = 0;
    int                     cycles     = 0;
    logic [15:0]            exp_pins [4] = '{16'ha500, 16'hac00, 16'hac70, 16'hac73};

    always #2 mclk = ~mclk;

    ppo_top i_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_match(timer_match), .pulse_out(pulse_out));
    ppo_timer_model i_tmr (.mclk(mclk), .timer_match(timer_match), .pin_dir(pin_dir));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input ppo_byte_t d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input ppo_byte_t exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
        @(posedge mclk);
    endtask : rd

    task automatic trig(input int ch, input logic [15:0] exp);
        i_tmr.fire(ch);
        #1 chk(pulse_out & pin_dir, exp);
        @(posedge mclk);
    endtask : trig

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(pulse_out, 16'h0000);
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], 8'h00);
        end
        rd(`PPO_TRIG_SEL, 8'hff);
        rd(4'hf, 8'h00);
        $display("reset values done");
    endtask : t_reset

    task automatic t_cpu_write;
        wr(`PPO_OUT_HI, 8'h5a);
        chk(pulse_out, 16'h5a00);
        wr(`PPO_ENA_HI, 8'h0f);
        wr(`PPO_OUT_HI, 8'hff);
        rd(`PPO_OUT_HI, 8'hfa);
        $display("cpu write done");
    endtask : t_cpu_write

    task automatic t_trigger;
        wr(`PPO_STG_HI, 8'h35);
        wr(`PPO_STG_HI_ALT, 8'h0f);
        rd(`PPO_STG_HI, 8'h35);
        rd(`PPO_STG_HI_ALT, 8'h00);
        wr(`PPO_STG_LO, 8'h3c);
        rd(`PPO_STG_LO, 8'h3c);
        trig(2, 16'hfa00);
        trig(3, 16'hf500);
        $display("trigger done");
    endtask : t_trigger

    task automatic t_groups;
        wr(`PPO_TRIG_SEL, 8'h1b);
        wr(`PPO_ENA_HI, 8'hff);
        wr(`PPO_ENA_LO, 8'hff);
        wr(`PPO_OUT_LO, 8'h55);
        chk(pulse_out, 16'hf500);
        wr(`PPO_STG_HI, 8'ha0);
        rd(`PPO_STG_HI, 8'haf);
        wr(`PPO_STG_HI_ALT, 8'h0c);
        rd(`PPO_STG_HI_ALT, 8'hfc);
        wr(`PPO_STG_LO, 8'h70);
        wr(`PPO_STG_LO_ALT, 8'h03);
        rd(`PPO_STG_LO, 8'h7f);
        rd(`PPO_STG_LO_ALT, 8'hf3);
        for (int ch = 0; ch < 4; ch++) begin
            trig(ch, exp_pins[ch]);
        end
        wr(`PPO_TRIG_SEL, 8'he4);
        rd(`PPO_TRIG_SEL, 8'he4);
        wr(`PPO_STG_HI_ALT, 8'h05);
        trig(2, 16'ha573);
        $display("group triggers done");
    endtask : t_groups

    task automatic t_reset_mid;
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(pulse_out, 16'h0000);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(`PPO_TRIG_SEL, 8'hff);
        rd(`PPO_OUT_HI, `PPO_OUT_RST);
        $display("mid-run reset done");
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_cpu_write();
        t_trigger();
        t_groups();
        t_reset_mid();
        end_of_test();
    end
endmodule : ppo_top_tb
